// [logic/cir_interrupt_response.sv]
// Interrupt acceptance, masking, priority and vector forming for the CPU.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cir_interrupt_response import cir_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmiN,
  input wire logic maskLine0N,
  input wire logic maskLine1N,
  input wire logic maskLine2N,
  input wire logic [9:0] periphReq,
  input wire logic samplePoint,
  input wire logic thirdStateEdge,
  input wire logic [7:0] dataIn,
  input wire logic opcodeUndef,
  output logic ackActive,
  output logic opcodeFetchStrobeN,
  output logic ioStrobeN,
  output logic waitStateReq,
  output logic vectorValid,
  output logic [15:0] vectorAddr,
  output logic tableFetch,
  output logic opcodeValid,
  output logic [7:0] opcode,
  output logic trapReq,
  output logic pushPc,
  output logic popPc,
  output logic dmaMasterEnable
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  cirState_t state_q;
  logic gie_q;
  logic sie_q;
  logic [1:0] mode_q;
  logic dme_q;
  logic trap_q;
  logic [2:0] lineEn_q;
  logic [2:0] vecLow_q;
  logic [7:0] vecPage_q;
  logic [1:0] waitCnt_q;
  logic ext0Mode0_q;
  logic ackActive_q;
  logic fetchN_q;
  logic ioN_q;
  logic waitReq_q;
  logic vecValid_q;
  logic [15:0] vecAddr_q;
  logic tableFetch_q;
  logic opValid_q;
  logic [7:0] opcode_q;
  logic trapReq_q;
  logic pushPc_q;
  logic popPc_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic nmiPending;
  logic nmiTake;
  logic line0Req;
  logic [CIR_NUM_VEC-1:0] vecReq;
  cirPick_t pick;
  logic sampleNow;
  logic takeLine0;
  logic takeVec;
  logic busWr;
  logic busAcc;
  logic cmdWr;
  logic mapped;
  logic [31:0] rdMux;
  logic t3Capture;

  // ************************************************************
  // Request gating and priority.
  // ************************************************************

  // Edge catcher for the non-maskable line; it ignores every enable bit.
  cir_nmi_latch u_nmi (
    .clk(clk),
    .resetn(resetn),
    .nmiN(nmiN),
    .take(nmiTake),
    .pending(nmiPending)
  );

  // Level requests are gated by the global and per-line enables.
  assign line0Req = ~maskLine0N & gie_q & lineEn_q[0];
  assign vecReq[0] = ~maskLine1N & gie_q & lineEn_q[1];
  assign vecReq[1] = ~maskLine2N & gie_q & lineEn_q[2];
  // Peripheral requests arrive already gated by their own enable bits.
  assign vecReq[CIR_NUM_VEC-1:2] = periphReq & {10{gie_q}};

  cir_vector_pick u_pick (
    .req(vecReq),
    .pick(pick)
  );

  // Sampling happens only between acknowledges; DMA activity is no bar.
  assign sampleNow = samplePoint & state_q[0];
  assign nmiTake = sampleNow & nmiPending;
  assign takeLine0 = sampleNow & ~nmiPending & line0Req;
  assign takeVec = sampleNow & ~nmiPending & ~line0Req & pick.valid;
  assign t3Capture = state_q[2] & thirdStateEdge;

  // ************************************************************
  // APB slave decode.
  // ************************************************************

  // Writes act only at the edge where the access phase sees pready high.
  assign busAcc = psel & penable & pready_q;
  assign busWr = busAcc & pwrite;
  assign cmdWr = busWr & (paddr == CIR_ADDR_CMD);

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      CIR_ADDR_CTRL: begin
        rdMux[CIR_CTRL_GIE] = gie_q;
        rdMux[CIR_CTRL_SIE] = sie_q;
        rdMux[CIR_CTRL_MODE_LO +: 2] = mode_q;
        rdMux[CIR_CTRL_DME] = dme_q;
      end
      CIR_ADDR_TRAP_CTRL: begin
        rdMux[CIR_TC_TRAP] = trap_q;
        rdMux[2:0] = lineEn_q;
      end
      CIR_ADDR_VEC_LOW: rdMux[7:5] = vecLow_q;
      CIR_ADDR_VEC_PAGE: rdMux[7:0] = vecPage_q;
      CIR_ADDR_CMD: rdMux = 32'h0000_0000;
      CIR_ADDR_STATUS: begin
        rdMux[15:0] = vecAddr_q;
        rdMux[CIR_ST_BUSY] = ~state_q[0];
        rdMux[CIR_ST_NMI_PEND] = nmiPending;
      end
      default: mapped = 1'b0;
    endcase
  end

  // One wait cycle per access keeps every bus output on a flip-flop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      prdata_q <= (psel & penable & ~pwrite) ? rdMux : 32'h0000_0000;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
    end
  end

  // ************************************************************
  // Enable flags and mode.
  // ************************************************************

  // Hardware acceptance outranks a command written in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gie_q <= 1'b0;
      sie_q <= 1'b0;
    end else if (nmiTake) begin
      sie_q <= gie_q;
      gie_q <= 1'b0;
    end else if (takeLine0 | takeVec) begin
      gie_q <= 1'b0;
      sie_q <= 1'b0;
    end else if (cmdWr & pwdata[CIR_CMD_ENABLE]) begin
      gie_q <= 1'b1;
      sie_q <= 1'b1;
    end else if (cmdWr & pwdata[CIR_CMD_MASK_ALL]) begin
      gie_q <= 1'b0;
      sie_q <= 1'b0;
    end else if (cmdWr & pwdata[CIR_CMD_NM_RETURN]) begin
      gie_q <= sie_q;
    end
  end

  // Response mode of line 0; single-chip users should pick mode 1.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= CIR_MODE_RESET;
    end else if (cmdWr & pwdata[CIR_CMD_SET_MODE]) begin
      mode_q <= pwdata[CIR_CMD_MODE_LO +: 2];
    end
  end

  // DMA master enable: software sets it, an accepted NMI clears it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dme_q <= 1'b0;
    end else if (nmiTake) begin
      dme_q <= 1'b0;
    end else if (busWr & (paddr == CIR_ADDR_CTRL)) begin
      dme_q <= pwdata[CIR_CTRL_DME];
    end
  end

  // ************************************************************
  // Trap control, vector low and vector page registers.
  // ************************************************************

  // Trap flag: software may only clear it, and a new trap wins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap_q <= 1'b0;
      lineEn_q <= CIR_LINE_EN_RESET;
    end else begin
      if (t3Capture & ext0Mode0_q & opcodeUndef) begin
        trap_q <= 1'b1;
      end else if (busWr & (paddr == CIR_ADDR_TRAP_CTRL) & ~pwdata[CIR_TC_TRAP]) begin
        trap_q <= 1'b0;
      end
      if (busWr & (paddr == CIR_ADDR_TRAP_CTRL)) begin
        lineEn_q <= pwdata[2:0];
      end
    end
  end

  // The page places the table on 256-byte bounds, the low bits on 32.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vecLow_q <= CIR_VEC_LOW_RESET;
      vecPage_q <= CIR_VEC_PAGE_RESET;
    end else begin
      if (busWr & (paddr == CIR_ADDR_VEC_LOW)) begin
        vecLow_q <= pwdata[7:5];
      end
      if (busWr & (paddr == CIR_ADDR_VEC_PAGE)) begin
        vecPage_q <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Acknowledge sequencer.
  // ************************************************************

  // Line 0 in any mode but 1 reads the data lines; the rest finish at once.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= CIR_IDLE;
      waitCnt_q <= 2'h0;
      ext0Mode0_q <= 1'b0;
    end else begin
      unique case (state_q)
        CIR_IDLE: begin
          if (takeLine0 & (mode_q != 2'h1)) begin
            state_q <= CIR_WAITS;
            waitCnt_q <= CIR_EXT_WAIT_STATES;
            ext0Mode0_q <= (mode_q == 2'h0);
          end
        end
        CIR_WAITS: begin
          waitCnt_q <= waitCnt_q - 2'h1;
          if (waitCnt_q == 2'h1) begin
            state_q <= CIR_DATA;
          end
        end
        CIR_DATA: begin
          if (thirdStateEdge) begin
            state_q <= CIR_IDLE;
          end
        end
      endcase
    end
  end

  // Strobes sit low for the whole external fetch and high otherwise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ackActive_q <= 1'b0;
      fetchN_q <= 1'b1;
      ioN_q <= 1'b1;
      waitReq_q <= 1'b0;
    end else begin
      ackActive_q <= (takeLine0 | takeVec) | (~state_q[0] & ~t3Capture);
      fetchN_q <= ~((takeLine0 & (mode_q != 2'h1)) | state_q[1] | (state_q[2] & ~thirdStateEdge));
      ioN_q <= ~((takeLine0 & (mode_q != 2'h1)) | state_q[1] | (state_q[2] & ~thirdStateEdge));
      waitReq_q <= (takeLine0 & (mode_q != 2'h1)) | (state_q[1] & (waitCnt_q != 2'h1));
    end
  end

  // ************************************************************
  // Vector, stack and opcode outputs.
  // ************************************************************

  // Each pulse stands for one cycle; the address holds until replaced.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vecValid_q <= 1'b0;
      vecAddr_q <= 16'h0000;
      tableFetch_q <= 1'b0;
      pushPc_q <= 1'b0;
      opValid_q <= 1'b0;
      opcode_q <= 8'h00;
      trapReq_q <= 1'b0;
    end else begin
      vecValid_q <= 1'b0;
      pushPc_q <= 1'b0;
      opValid_q <= 1'b0;
      trapReq_q <= 1'b0;
      if (nmiTake) begin
        vecValid_q <= 1'b1;
        vecAddr_q <= CIR_NMI_RESTART;
        tableFetch_q <= 1'b0;
        pushPc_q <= 1'b1;
      end else if (takeLine0 & (mode_q == 2'h1)) begin
        vecValid_q <= 1'b1;
        vecAddr_q <= CIR_MODE1_RESTART;
        tableFetch_q <= 1'b0;
        pushPc_q <= 1'b1;
      end else if (takeVec) begin
        vecValid_q <= 1'b1;
        vecAddr_q <= {vecPage_q, vecLow_q, pick.code};
        tableFetch_q <= 1'b1;
        pushPc_q <= 1'b1;
      end else if (t3Capture & ext0Mode0_q) begin
        // Mode 0 runs the fetched opcode; the PC is not stacked here.
        opcode_q <= dataIn;
        opValid_q <= ~opcodeUndef;
        trapReq_q <= opcodeUndef;
      end else if (t3Capture) begin
        vecValid_q <= 1'b1;
        vecAddr_q <= {vecPage_q, dataIn};
        tableFetch_q <= 1'b1;
        pushPc_q <= 1'b1;
      end
    end
  end

  // Both return commands pop the stacked program counter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      popPc_q <= 1'b0;
    end else begin
      popPc_q <= cmdWr & (pwdata[CIR_CMD_NM_RETURN] | pwdata[CIR_CMD_MK_RETURN]);
    end
  end

  // ************************************************************
  // Output drive.
  // ************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ackActive = ackActive_q;
  assign opcodeFetchStrobeN = fetchN_q;
  assign ioStrobeN = ioN_q;
  assign waitStateReq = waitReq_q;
  assign vectorValid = vecValid_q;
  assign vectorAddr = vecAddr_q;
  assign tableFetch = tableFetch_q;
  assign opcodeValid = opValid_q;
  assign opcode = opcode_q;
  assign trapReq = trapReq_q;
  assign pushPc = pushPc_q;
  assign popPc = popPc_q;
  assign dmaMasterEnable = dme_q;

endmodule
`default_nettype wire

// [pkg/cir_pkg.sv]
// Shared constants, register map and carrier types of the interrupt response block.
package cir_pkg;

  // ************************************************************
  // Register map (byte addresses on the APB).
  // ************************************************************
  localparam logic [7:0] CIR_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CIR_ADDR_TRAP_CTRL = 8'h04;
  localparam logic [7:0] CIR_ADDR_VEC_LOW = 8'h08;
  localparam logic [7:0] CIR_ADDR_VEC_PAGE = 8'h0c;
  localparam logic [7:0] CIR_ADDR_CMD = 8'h10;
  localparam logic [7:0] CIR_ADDR_STATUS = 8'h14;

  // Control register fields.
  localparam int CIR_CTRL_GIE = 0;
  localparam int CIR_CTRL_SIE = 1;
  localparam int CIR_CTRL_MODE_LO = 2;
  localparam int CIR_CTRL_DME = 4;

  // Trap control register fields.
  localparam int CIR_TC_TRAP = 7;

  // Command register bits 0 to 4, each one an instruction effect; bits 5 and 6 give the mode.
  localparam int CIR_CMD_ENABLE = 0;
  localparam int CIR_CMD_MASK_ALL = 1;
  localparam int CIR_CMD_NM_RETURN = 2;
  localparam int CIR_CMD_MK_RETURN = 3;
  localparam int CIR_CMD_SET_MODE = 4;
  localparam int CIR_CMD_MODE_LO = 5;

  // Status register fields.
  localparam int CIR_ST_BUSY = 16;
  localparam int CIR_ST_NMI_PEND = 17;

  // ************************************************************
  // Reset values, fixed restart addresses and timing counts.
  // ************************************************************
  localparam logic [1:0] CIR_MODE_RESET = 2'h0;
  localparam logic [2:0] CIR_LINE_EN_RESET = 3'h1;
  localparam logic [7:0] CIR_VEC_PAGE_RESET = 8'h00;
  localparam logic [2:0] CIR_VEC_LOW_RESET = 3'h0;
  localparam logic [15:0] CIR_NMI_RESTART = 16'h0066;
  localparam logic [15:0] CIR_MODE1_RESTART = 16'h0038;
  localparam logic [1:0] CIR_EXT_WAIT_STATES = 2'h2;
  localparam int CIR_NUM_VEC = 12;

  // Fixed low codes, index 0 is the highest priority.
  localparam logic [4:0] CIR_LOW_CODE [CIR_NUM_VEC] = '{
    5'h00, 5'h02, 5'h12, 5'h14, 5'h16, 5'h04,
    5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10};

  // ************************************************************
  // Carrier types.
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [4:0] code;
  } cirPick_t;

  typedef enum logic [2:0] {
    CIR_IDLE = 3'b001,
    CIR_WAITS = 3'b010,
    CIR_DATA = 3'b100
  } cirState_t;

endpackage

// [logic/cir_nmi_latch.sv]
// Falling-edge catcher that holds a non-maskable request until it is taken.
`timescale 1ns/1ps
`default_nettype none
module cir_nmi_latch import cir_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic nmiN,
  input wire logic take,
  output logic pending
);

  logic prev_q;
  logic pend_q;
  logic pend_d;

  // The previous level resets high so a line held low at reset counts as an edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= nmiN;
    end
  end

  // A new edge in the cycle of acceptance wins, so no edge is lost.
  always_comb begin
    pend_d = (prev_q & ~nmiN) | (pend_q & ~take);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

endmodule
`default_nettype wire

// [logic/cir_vector_pick.sv]
// Fixed-priority selector of the vectored sources and their low code.
`timescale 1ns/1ps
`default_nettype none
module cir_vector_pick import cir_pkg::*; (
  input wire logic [CIR_NUM_VEC-1:0] req,
  output cirPick_t pick
);

  logic [CIR_NUM_VEC:0] above;
  logic [4:0] part [CIR_NUM_VEC+1];

  assign above[0] = 1'b0;
  assign part[0] = 5'h00;

  // Each entry wins only when no higher entry asks; losers stay pending.
  genvar i;
  generate
    for (i = 0; i < CIR_NUM_VEC; i++) begin : g_ent
      assign above[i+1] = above[i] | req[i];
      assign part[i+1] = part[i] | ({5{req[i] & ~above[i]}} & CIR_LOW_CODE[i]);
    end
  endgenerate

  // One driver for the whole carrier keeps the struct a single-source variable.
  assign pick = '{valid: above[CIR_NUM_VEC], code: part[CIR_NUM_VEC]};

endmodule
`default_nettype wire

// [verification/cir_checker.sv]
// Concurrent checks on the acknowledge ports of the interrupt response block.
`timescale 1ns/1ps
`default_nettype none
module cir_checker import cir_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic samplePoint,
  input wire logic thirdStateEdge,
  input wire logic [7:0] dataIn,
  input wire logic opcodeUndef,
  input wire logic ackActive,
  input wire logic opcodeFetchStrobeN,
  input wire logic ioStrobeN,
  input wire logic waitStateReq,
  input wire logic vectorValid,
  input wire logic [15:0] vectorAddr,
  input wire logic tableFetch,
  input wire logic opcodeValid,
  input wire logic trapReq,
  input wire logic pushPc
);
  // ********************
  // Acknowledge checks
  // ********************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // An external fetch pulls both strobes and inserts exactly two wait states.
  wait_count_a: assert property ($rose(waitStateReq) |=> waitStateReq ##1 !waitStateReq)
    else $error("wait state count wrong");
  fetch_strobes_a: assert property (waitStateReq |-> !opcodeFetchStrobeN && !ioStrobeN)
    else $error("strobes high in wait state");
  ack_span_a: assert property (waitStateReq |-> ackActive)
    else $error("wait state outside acknowledge");
  // A vector is given with the strobes back high, so vectored sources never pull them.
  strobes_idle_a: assert property (vectorValid |-> opcodeFetchStrobeN && ioStrobeN)
    else $error("strobes low at vector");
  vector_cause_a: assert property (vectorValid |-> $past(samplePoint) || $past(thirdStateEdge))
    else $error("vector without cause");
  fixed_restart_a: assert property (vectorValid && !tableFetch |->
    vectorAddr == 16'h0066 || vectorAddr == 16'h0038)
    else $error("bad fixed restart");
  table_byte_a: assert property ($past(thirdStateEdge) && vectorValid |->
    tableFetch && vectorAddr[7:0] == $past(dataIn))
    else $error("table byte not from data lines");
  // Internal low codes are even and never above the largest listed code.
  low_code_a: assert property (vectorValid && tableFetch && !$past(thirdStateEdge) |->
    !vectorAddr[0] && vectorAddr[4:0] <= 5'h16)
    else $error("bad fixed low code");
  push_pair_a: assert property (pushPc |-> vectorValid)
    else $error("push without vector");
  mode0_push_a: assert property (opcodeValid || trapReq |-> !pushPc && !vectorValid)
    else $error("mode 0 pushed");
  trap_cause_a: assert property (trapReq |-> $past(thirdStateEdge) && $past(opcodeUndef))
    else $error("trap without bad opcode");
endmodule
`default_nettype wire

// [verification/cir_ext_dev.sv]
// Behavioural model of an external device answering a vector or opcode fetch.
`timescale 1ns/1ps
`default_nettype none
module cir_ext_dev (
  input wire logic clk,
  input wire logic resetn,
  input wire logic opcodeFetchStrobeN,
  input wire logic ioStrobeN,
  input wire logic waitStateReq,
  input wire logic [7:0] ackByte,
  input wire logic [3:0] delay,
  output logic thirdStateEdge,
  output logic [7:0] dataIn
);
  // ********************
  // Fetch answer
  // ********************
  logic [3:0] cnt_q;
  logic done_q;
  logic fetch;
  assign fetch = !opcodeFetchStrobeN && !ioStrobeN && !waitStateReq;
  // Answers once per fetch after a chosen delay; idle lines toggle so a stale byte is never read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      thirdStateEdge <= 1'b0;
      dataIn <= 8'h00;
    end else if (fetch && !done_q && cnt_q == delay) begin
      thirdStateEdge <= 1'b1;
      dataIn <= ackByte;
      done_q <= 1'b1;
    end else begin
      thirdStateEdge <= 1'b0;
      dataIn <= ~dataIn;
      cnt_q <= (fetch && !done_q) ? cnt_q + 4'h1 : 4'h0;
      done_q <= done_q && fetch;
    end
  end
endmodule
`default_nettype wire

// [verification/test_cir_interrupt_response.sv]
// Self-checking testbench of the interrupt response block.
`timescale 1ns/1ps
`default_nettype none
module test_cir_interrupt_response import cir_pkg::*; ;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, dataIn, ackByte, opcode;
  logic [31:0] pwdata, prdata;
  logic nmiN, maskLine0N, maskLine1N, maskLine2N, samplePoint, thirdStateEdge;
  logic opcodeUndef, ackActive, opcodeFetchStrobeN, ioStrobeN, waitStateReq;
  logic vectorValid, tableFetch, opcodeValid, trapReq, pushPc, popPc, dmaMasterEnable;
  logic [9:0] periphReq;
  logic [15:0] vectorAddr, gotAddr;
  logic [3:0] delay;
  logic hit, gotPush, gotTrap, gotErr;
  int errCount, nCompared, popCount;
  // Low codes of the vectored sources, highest priority first.
  localparam logic [4:0] CODES [12] = '{5'h00, 5'h02, 5'h12, 5'h14, 5'h16, 5'h04,
    5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10};

  cir_interrupt_response dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nmiN, .maskLine0N, .maskLine1N, .maskLine2N, .periphReq,
    .samplePoint, .thirdStateEdge, .dataIn, .opcodeUndef, .ackActive, .opcodeFetchStrobeN,
    .ioStrobeN, .waitStateReq, .vectorValid, .vectorAddr, .tableFetch, .opcodeValid,
    .opcode, .trapReq, .pushPc, .popPc, .dmaMasterEnable);
  cir_ext_dev ext_u (.clk, .resetn, .opcodeFetchStrobeN, .ioStrobeN, .waitStateReq,
    .ackByte, .delay, .thirdStateEdge, .dataIn);

  // ********************
  // Shared tasks
  // ********************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts stack pops at the edge after the pulse has settled.
  always @(posedge clk) begin
    if (popPc === 1'b1) begin
      popCount <= popCount + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; an idle cycle follows so no strobe is driven twice in one step.
  task automatic apb(input logic isWr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave takes; only the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    gotErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Pulses the sampling point and records the first answer, looked at mid-cycle.
  task automatic take();
    samplePoint <= 1'b1;
    @(posedge clk);
    samplePoint <= 1'b0;
    hit = 1'b0;
    for (int n = 0; n < 20 && !hit; n++) begin
      @(negedge clk);
      hit = (vectorValid | opcodeValid | trapReq) === 1'b1;
      gotAddr = vectorAddr;
      gotPush = pushPc;
      gotTrap = trapReq;
    end
    @(posedge clk);
  endtask
  task automatic nmiPulse();
    nmiN <= 1'b0;
    repeat (2) @(posedge clk);
    nmiN <= 1'b1;
    take();
  endtask
  task automatic lineZero(input logic [31:0] mode);
    wr(CIR_ADDR_CMD, mode);
    wr(CIR_ADDR_CMD, 32'h1);
    maskLine0N <= 1'b0;
    take();
    maskLine0N <= 1'b1;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic testReset();
    rd(CIR_ADDR_CTRL, 32'h0);
    rd(CIR_ADDR_TRAP_CTRL, 32'h1);
    rd(CIR_ADDR_VEC_LOW, 32'h0);
    rd(CIR_ADDR_VEC_PAGE, 32'h0);
    rd(8'h18, 32'h0);
    chk(gotErr, 1'b1);
    $display("reset test done");
  endtask
  // The request is released before sampling, so only the held edge can be taken.
  task automatic testNmi();
    wr(CIR_ADDR_CTRL, 32'h10);
    chk(dmaMasterEnable, 1'b1);
    wr(CIR_ADDR_CMD, 32'h1);
    nmiPulse();
    chk(gotAddr, 16'h0066);
    chk(gotPush, 1'b1);
    chk(dmaMasterEnable, 1'b0);
    rd(CIR_ADDR_CTRL, 32'h2);
    wr(CIR_ADDR_CMD, 32'h4);
    rd(CIR_ADDR_CTRL, 32'h3);
    chk(popCount, 1);
    wr(CIR_ADDR_CMD, 32'h8);
    wr(CIR_ADDR_CMD, 32'h2);
    nmiPulse();
    chk(gotAddr, 16'h0066);
    chk(popCount, 2);
    $display("nmi test done");
  endtask
  task automatic testModeOne();
    wr(CIR_ADDR_CMD, 32'h30);
    maskLine0N <= 1'b0;
    take();
    chk(hit, 1'b0);
    lineZero(32'h30);
    chk(gotAddr, 16'h0038);
    chk(gotPush, 1'b1);
    rd(CIR_ADDR_CTRL, 32'h4);
    $display("mode 1 test done");
  endtask
  task automatic testModeTwo();
    wr(CIR_ADDR_VEC_PAGE, 32'h5a);
    rd(CIR_ADDR_VEC_PAGE, 32'h5a);
    ackByte <= 8'h34;
    delay <= 4'h3;
    lineZero(32'h50);
    chk(gotAddr, 16'h5a34);
    chk(tableFetch, 1'b1);
    chk(gotPush, 1'b1);
    $display("mode 2 test done");
  endtask
  task automatic testModeZero();
    ackByte <= 8'hc7;
    delay <= 4'h0;
    lineZero(32'h10);
    chk(opcode, 8'hc7);
    chk(gotPush, 1'b0);
    opcodeUndef <= 1'b1;
    lineZero(32'h10);
    opcodeUndef <= 1'b0;
    chk(gotTrap, 1'b1);
    rd(CIR_ADDR_TRAP_CTRL, 32'h81);
    wr(CIR_ADDR_TRAP_CTRL, 32'h1);
    $display("mode 0 test done");
  endtask
  // Every source waits at once; each is served in turn and then withdrawn.
  task automatic testVectored();
    wr(CIR_ADDR_VEC_LOW, 32'ha0);
    maskLine1N <= 1'b0;
    maskLine2N <= 1'b0;
    periphReq <= 10'h3ff;
    take();
    chk(hit, 1'b0);
    wr(CIR_ADDR_CMD, 32'h1);
    take();
    chk(gotAddr, 16'h5ab2);
    wr(CIR_ADDR_TRAP_CTRL, 32'h7);
    maskLine0N <= 1'b0;
    wr(CIR_ADDR_CMD, 32'h1);
    nmiPulse();
    chk(gotAddr, 16'h0066);
    lineZero(32'h30);
    chk(gotAddr, 16'h0038);
    for (int k = 0; k < 12; k++) begin
      wr(CIR_ADDR_CMD, 32'h1);
      take();
      chk(gotAddr, {8'h5a, 3'h5, CODES[k]});
      if (k == 0) maskLine1N <= 1'b1;
      else if (k == 1) maskLine2N <= 1'b1;
      else periphReq[k-2] <= 1'b0;
    end
    $display("vectored test done");
  endtask

  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short far beyond the few hundred cycles the run needs.
  initial begin
    #3000000;
    errCount++;
    endOfTest();
  end
  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, samplePoint, opcodeUndef} = 5'h00;
    {nmiN, maskLine0N, maskLine1N, maskLine2N} = 4'hf;
    paddr = 8'h00;
    pwdata = 32'h0;
    periphReq = 10'h000;
    ackByte = 8'h00;
    delay = 4'h0;
    errCount = 0;
    nCompared = 0;
    popCount = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    testReset();
    testNmi();
    testModeOne();
    testModeTwo();
    testModeZero();
    testVectored();
    endOfTest();
  end
endmodule
bind cir_interrupt_response cir_checker chk_u (.*);
`default_nettype wire
